/* File: hdl/scr_supervisor_defines.svh */
// offsets, reset values and timing constants of the thyristor supervisor
`ifndef SCR_SUPERVISOR_DEFINES_SVH
`define SCR_SUPERVISOR_DEFINES_SVH

`define REG_CTRL 5'h00
`define REG_MODE 5'h04
`define REG_FAULT_CFG 5'h08
`define REG_RAMP 5'h0C
`define REG_LIMIT 5'h10
`define REG_STATUS 5'h14
`define REG_FEEDBACK 5'h18

`define CTRL_ON_BIT 0
`define CTRL_OFF_BIT 1

`define MODE_RESET 12'h000
`define FAULT_CFG_RESET 10'h220
`define RAMP_RESET 16'h1087
`define LIMIT_RESET 10'h3FF

`define STARTUP_ON 2'h0
`define STARTUP_OFF 2'h1
`define STARTUP_LAST 2'h2

`define DELAY_OFF 10'h3FF
`define DELAY_90 10'h200
`define LIVE_ZERO_OFFSET 10'h0CD
`define LIVE_ZERO_GAIN 20'h00500
`define BURST_FRAME 7'h64

`define RAMP_TIME_MIN_S 5'h01
`define RAMP_TIME_MAX_S 5'h1E
`define MAINS_HZ 50
`define HALF_CYCLES_PER_S (2 * `MAINS_HZ)
`define RAMP_SPAN_Q16 (32'h000003FF << 16)

`endif

/* File: hdl/scr_supervisor_pkg.sv */
// types shared by the thyristor supervisor
package scr_supervisor_pkg;

    typedef enum logic [1:0] {open_loop_control, voltage_control, current_control,
                              combined_voltage_current_control} ctrl_mode_t;

    typedef enum logic [1:0] {cur_src_analog, cur_src_transformer, cur_src_shunt, cur_src_spare} cur_src_t;

    typedef enum logic [1:0] {st_off, st_ramp_up, st_run, st_ramp_down} ramp_state_t;

    typedef struct packed {
        logic rotation_cw_cfg;
        logic [4:0] live_zero_en;
        logic volt_src_direct;
        cur_src_t cur_src;
        ctrl_mode_t ctrl_mode;
        logic burst_packet_firing;
    } mode_cfg_t;

    typedef struct packed {
        logic [1:0] startup_sel;
        logic auto_resume;
        logic interlock_en;
        logic fault_gen_en;
        logic block_active_high;
        logic inhibit_active_high;
        logic [2:0] source_mask;
    } fault_cfg_t;

    typedef struct packed {
        logic [3:0] soft_init_periods;
        logic [4:0] off_time_s;
        logic [4:0] on_time_s;
        logic soft_off_en;
        logic soft_on_en;
    } ramp_cfg_t;

endpackage : scr_supervisor_pkg

/* File: hdl/scr_fault_ramp_supervisor.sv */
// fault supervision, mode selection and soft ramps of the thyristor firing controller
//
// Functional notes
// - fault built from sync, halt, overcurrent only
// - each source masked separately by software
// - sync fault on reversed rotation or lost phase
// - halt on inhibit or block, own polarity
// - overcurrent when feedback exceeds programmed limit
// - pulses inhibited only when on and faulted
// - fault stops firing and sets visible flags
// - fault clears once all sources inactive, unless interlock is enabled
// - auto resume if configured, else await on
// - fault relay follows the fault signal
// - interlock latches until clear plus off confirm
// - power-up enters on, off or last state
// - default start-up restores last state
// - soft on lowers delay to the setpoint
// - soft off raises delay to off state
// - ramp times programmable 1 to 30 s
// - closed loop only in phase-angle firing
// - combined mode takes more restrictive demand
// - soft-init periods at 90 degrees per packet
// - selectable feedback sources, analog by default
// - live-zero 4-20 mA per input
// - burst packets over 100 half-period frame
`timescale 1ns/1ns
`default_nettype none
`include "scr_supervisor_defines.svh"

module scr_fault_ramp_supervisor
    import scr_supervisor_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [1:0] startup_sel_in,
    input wire logic last_state_on_in,
    input wire logic confirm_off_in,
    input wire logic zero_cross,
    input wire logic rotation_cw_in,
    input wire logic [2:0] sync_lost_in,
    input wire logic inhibit_in,
    input wire logic external_block_in,
    input wire logic [9:0] alpha_setpoint_in,
    input wire logic [9:0] voltage_setpoint_in,
    input wire logic [9:0] current_setpoint_in,
    input wire logic [9:0] transformer_current_in,
    input wire logic [9:0] shunt_current_in,
    input wire logic [9:0] analog_current_feedback_in,
    input wire logic [9:0] direct_voltage_in,
    input wire logic [9:0] analog_voltage_feedback_in,
    input wire logic [9:0] pid_voltage_delay_in,
    input wire logic [9:0] pid_current_delay_in,
    output logic [9:0] phase_delay,
    output logic fire_enable,
    output logic soft_init_active,
    output logic pulse_inhibit,
    output logic fault_relay,
    output logic [2:0] fault_flags,
    output logic system_on,
    output logic [9:0] alpha_setpoint,
    output logic [9:0] voltage_setpoint,
    output logic [9:0] current_setpoint,
    output logic [9:0] current_feedback,
    output logic [9:0] voltage_feedback
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    mode_cfg_t mode_cfg;
    fault_cfg_t fault_cfg;
    ramp_cfg_t ramp_cfg;
    logic [9:0] max_current_limit;
    logic bus_ack;
    logic on_cmd;
    logic off_cmd;
    logic startup_pending;
    logic run_req;
    logic fault_latched;
    logic fault_active_q;
    logic sync_fault;
    logic halt_fault;
    logic overcurrent_fault;
    logic fault_active;
    logic fault;
    logic fire_allowed;
    logic [9:0] raw_chan [5];
    logic [9:0] chan_val [5];
    logic [9:0] cur_raw;
    logic [9:0] demand_delay;
    ramp_state_t ramp_state;
    ramp_state_t next_ramp_state;
    logic [25:0] delay_q;
    logic [25:0] target_q;
    logic [31:0] on_step;
    logic [31:0] off_step;
    logic [6:0] frame_cnt;
    logic [7:0] init_cnt;
    logic [6:0] packet_len;
    logic [16:0] packet_prod;
    logic burst_on;
    logic [1:0] run_state_code;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [9:0] live_zero(input logic [9:0] v);
        logic [19:0] p;
        p = 20'h00000;
        if (v < `LIVE_ZERO_OFFSET) begin
            live_zero = 10'h000;
        end else begin
            p = 20'({10'h000, v - `LIVE_ZERO_OFFSET} * `LIVE_ZERO_GAIN);
            live_zero = p[19:10];
        end
    endfunction : live_zero

    function automatic logic [4:0] clamp_time(input logic [4:0] t);
        if (t < `RAMP_TIME_MIN_S) begin
            clamp_time = `RAMP_TIME_MIN_S;
        end else if (t > `RAMP_TIME_MAX_S) begin
            clamp_time = `RAMP_TIME_MAX_S;
        end else begin
            clamp_time = t;
        end
    endfunction : clamp_time

    function automatic logic [31:0] ramp_step(input logic [4:0] t);
        logic [31:0] div;
        div = 32'({27'h0000000, t} * 32'(`HALF_CYCLES_PER_S));
        ramp_step = `RAMP_SPAN_Q16 / div;
    endfunction : ramp_step

    ////////////////////////////////////////////////////////////////////////////////
    // avalon slave, one wait state

    assign waitrequest = (read | write) & ~bus_ack;
    assign on_cmd = write & bus_ack & (address == `REG_CTRL) & writedata[`CTRL_ON_BIT];
    assign off_cmd = (write & bus_ack & (address == `REG_CTRL) & writedata[`CTRL_OFF_BIT]) | confirm_off_in;

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (read | write) & ~bus_ack;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_cfg <= `MODE_RESET;
            ramp_cfg <= `RAMP_RESET;
            max_current_limit <= `LIMIT_RESET;
        end else if (write & bus_ack) begin
            unique case (address)
                `REG_MODE: mode_cfg <= writedata[11:0];
                `REG_RAMP: begin
                    ramp_cfg.soft_on_en <= writedata[0];
                    ramp_cfg.soft_off_en <= writedata[1];
                    ramp_cfg.on_time_s <= clamp_time(writedata[6:2]);
                    ramp_cfg.off_time_s <= clamp_time(writedata[11:7]);
                    ramp_cfg.soft_init_periods <= writedata[15:12];
                end
                `REG_LIMIT: max_current_limit <= writedata[9:0];
                default: begin
                end
            endcase
        end
    end

    // start-up selection caught from the strap after reset release
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_cfg <= `FAULT_CFG_RESET;
        end else if (startup_pending) begin
            fault_cfg.startup_sel <= startup_sel_in;
        end else if (write & bus_ack & (address == `REG_FAULT_CFG)) begin
            fault_cfg <= writedata[9:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            readdata <= 32'h00000000;
        end else if (read & ~bus_ack) begin
            unique case (address)
                `REG_MODE: readdata <= {20'h00000, mode_cfg};
                `REG_FAULT_CFG: readdata <= {22'h000000, fault_cfg};
                `REG_RAMP: readdata <= {16'h0000, ramp_cfg};
                `REG_LIMIT: readdata <= {22'h000000, max_current_limit};
                `REG_STATUS: readdata <= {14'h0000, phase_delay, run_state_code, system_on,
                                          fault_latched, fault, fault_flags};
                `REG_FEEDBACK: readdata <= {6'h00, voltage_feedback, 6'h00, current_feedback};
                default: readdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // input conditioning and feedback selection

    always_comb begin
        unique case (mode_cfg.cur_src)
            cur_src_transformer: cur_raw = transformer_current_in;
            cur_src_shunt: cur_raw = shunt_current_in;
            default: cur_raw = analog_current_feedback_in;
        endcase
    end

    assign raw_chan[0] = alpha_setpoint_in;
    assign raw_chan[1] = voltage_setpoint_in;
    assign raw_chan[2] = current_setpoint_in;
    assign raw_chan[3] = cur_raw;
    assign raw_chan[4] = mode_cfg.volt_src_direct ? direct_voltage_in : analog_voltage_feedback_in;

    for (genvar ch = 0; ch < 5; ch++) begin : g_chan
        always_ff @(posedge clk) begin
            if (srst) begin
                chan_val[ch] <= 10'h000;
            end else begin
                chan_val[ch] <= mode_cfg.live_zero_en[ch] ? live_zero(raw_chan[ch]) : raw_chan[ch];
            end
        end
    end

    assign alpha_setpoint = chan_val[0];
    assign voltage_setpoint = chan_val[1];
    assign current_setpoint = chan_val[2];
    assign current_feedback = chan_val[3];
    assign voltage_feedback = chan_val[4];

    ////////////////////////////////////////////////////////////////////////////////
    // fault sources

    assign sync_fault = ~fault_cfg.source_mask[0] &
                        ((rotation_cw_in != mode_cfg.rotation_cw_cfg) | (|sync_lost_in));
    assign halt_fault = ~fault_cfg.source_mask[1] &
                        ((inhibit_in == fault_cfg.inhibit_active_high) |
                         (external_block_in == fault_cfg.block_active_high));
    assign overcurrent_fault = ~fault_cfg.source_mask[2] & (current_feedback > max_current_limit);
    assign fault_active = fault_cfg.fault_gen_en & (sync_fault | halt_fault | overcurrent_fault);
    assign fault = fault_active | fault_latched;
    assign fire_allowed = run_req & ~fault;
    assign run_state_code = ramp_state;

    always_ff @(posedge clk) begin
        if (srst) begin
            fault_flags <= 3'h0;
            fault_relay <= 1'b0;
            pulse_inhibit <= 1'b0;
            fault_active_q <= 1'b0;
        end else begin
            fault_flags <= fault_cfg.fault_gen_en ? {overcurrent_fault, halt_fault, sync_fault} : 3'h0;
            fault_relay <= fault;
            pulse_inhibit <= system_on & fault;
            fault_active_q <= fault_active;
        end
    end

    // interlock: set wins over the confirming clear
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_latched <= 1'b0;
        end else if (fault_active & fault_cfg.interlock_en) begin
            fault_latched <= 1'b1;
        end else if (off_cmd) begin
            fault_latched <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // run request and power-up start

    always_ff @(posedge clk) begin
        if (srst) begin
            startup_pending <= 1'b1;
            run_req <= 1'b0;
        end else if (startup_pending) begin
            startup_pending <= 1'b0;
            run_req <= (startup_sel_in == `STARTUP_ON) |
                       ((startup_sel_in == `STARTUP_LAST) & last_state_on_in);
        end else if (off_cmd) begin
            run_req <= 1'b0;
        end else if (fault_active & ~fault_active_q & (fault_cfg.interlock_en | ~fault_cfg.auto_resume)) begin
            run_req <= 1'b0;
        end else if (on_cmd & ~fault_latched) begin
            run_req <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // demand selection

    always_comb begin
        if (mode_cfg.burst_packet_firing) begin
            demand_delay = `DELAY_OFF - alpha_setpoint;
        end else begin
            unique case (mode_cfg.ctrl_mode)
                open_loop_control: demand_delay = `DELAY_OFF - alpha_setpoint;
                voltage_control: demand_delay = pid_voltage_delay_in;
                current_control: demand_delay = pid_current_delay_in;
                combined_voltage_current_control: demand_delay =
                    (pid_voltage_delay_in > pid_current_delay_in) ? pid_voltage_delay_in : pid_current_delay_in;
            endcase
        end
    end

    assign target_q = {demand_delay, 16'h0000};
    assign on_step = ramp_step(ramp_cfg.on_time_s);
    assign off_step = ramp_step(ramp_cfg.off_time_s);

    ////////////////////////////////////////////////////////////////////////////////
    // soft ramp state machine

    always_comb begin
        next_ramp_state = ramp_state;
        unique case (ramp_state)
            st_off: begin
                if (fire_allowed) begin
                    next_ramp_state = (ramp_cfg.soft_on_en & ~mode_cfg.burst_packet_firing) ? st_ramp_up : st_run;
                end
            end
            st_ramp_up: begin
                if (~fire_allowed) begin
                    next_ramp_state = (ramp_cfg.soft_off_en & ~fault) ? st_ramp_down : st_off;
                end else if (zero_cross & (27'(delay_q) <= 27'(target_q) + 27'(on_step))) begin
                    next_ramp_state = st_run;
                end
            end
            st_run: begin
                if (~fire_allowed) begin
                    next_ramp_state = (ramp_cfg.soft_off_en & ~mode_cfg.burst_packet_firing & ~fault) ?
                                      st_ramp_down : st_off;
                end
            end
            st_ramp_down: begin
                if (fault) begin
                    next_ramp_state = st_off;
                end else if (fire_allowed) begin
                    next_ramp_state = st_ramp_up;
                end else if (zero_cross & (delay_q >= {`DELAY_OFF, 16'h0000} - 26'(off_step))) begin
                    next_ramp_state = st_off;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_state <= st_off;
        end else begin
            ramp_state <= next_ramp_state;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            delay_q <= {`DELAY_OFF, 16'h0000};
        end else begin
            unique case (next_ramp_state)
                st_off: delay_q <= {`DELAY_OFF, 16'h0000};
                st_run: delay_q <= target_q;
                st_ramp_up: begin
                    if (zero_cross) begin
                        delay_q <= delay_q - 26'(on_step);
                    end
                end
                st_ramp_down: begin
                    if (ramp_state == st_run) begin
                        delay_q <= target_q;
                    end else if (zero_cross) begin
                        delay_q <= delay_q + 26'(off_step);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // burst packets with soft-init periods

    assign packet_prod = 17'({7'h00, alpha_setpoint} * 17'd100) + 17'd512;
    assign packet_len = packet_prod[16:10];

    always_ff @(posedge clk) begin
        if (srst) begin
            frame_cnt <= 7'h00;
            init_cnt <= 8'h00;
            burst_on <= 1'b0;
        end else if (zero_cross) begin
            frame_cnt <= (frame_cnt == `BURST_FRAME - 7'h01) ? 7'h00 : frame_cnt + 7'h01;
            burst_on <= (frame_cnt < packet_len) & (ramp_state == st_run);
            init_cnt <= (frame_cnt == 7'h00) ? 8'h00 : ((init_cnt == 8'hFF) ? init_cnt : init_cnt + 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // firing outputs

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_delay <= `DELAY_OFF;
            fire_enable <= 1'b0;
            soft_init_active <= 1'b0;
            system_on <= 1'b0;
        end else begin
            system_on <= run_req;
            if (mode_cfg.burst_packet_firing) begin
                soft_init_active <= burst_on & (init_cnt < {3'h0, ramp_cfg.soft_init_periods, 1'b0});
                phase_delay <= (burst_on & (init_cnt < {3'h0, ramp_cfg.soft_init_periods, 1'b0})) ?
                               `DELAY_90 : 10'h000;
                fire_enable <= burst_on & ~fault;
            end else begin
                soft_init_active <= 1'b0;
                phase_delay <= delay_q[25:16];
                fire_enable <= (ramp_state != st_off) & ~fault;
            end
        end
    end

endmodule : scr_fault_ramp_supervisor
`default_nettype wire

/* File: sim/scr_operator_model.sv */
// operator and plant side model driving the fault inputs
`timescale 1ns/1ns
`default_nettype none
module scr_operator_model (
    input wire logic clk,
    input wire logic [2:0] fault_req,
    input wire logic confirm_req,
    output logic [2:0] sync_lost_in,
    output logic inhibit_in,
    output logic external_block_in,
    output logic confirm_off_in
);
    // one phase drops out, inhibit and block raised high
    always @(posedge clk) begin
        sync_lost_in <= {1'b0, fault_req[0], 1'b0};
        inhibit_in <= fault_req[1];
        external_block_in <= fault_req[2];
    end
    // ok button pressed only once all sources are quiet
    always @(posedge clk) begin
        confirm_off_in <= confirm_req && (fault_req == 3'h0);
    end
endmodule : scr_operator_model
`default_nettype wire

/* File: sim/scr_fault_ramp_supervisor_asserts.sv */
// port checker of the thyristor supervisor
`timescale 1ns/1ns
`default_nettype none
`include "scr_supervisor_defines.svh"
module scr_supervisor_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic fire_enable,
    input wire logic pulse_inhibit,
    input wire logic fault_relay,
    input wire logic [2:0] fault_flags
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_req_wait;
        (read || write) && waitrequest;
    endsequence
    sequence s_req_done;
        (read || write) && !waitrequest;
    endsequence
    a_first_wait: assert property ($rose(read || write) |-> s_req_wait)
        else $error("request not stalled in first cycle");
    a_one_wait: assert property (s_req_wait |=> s_req_done)
        else $error("request not answered after one wait state");
    a_zero_read: assert property (s_req_done and (read && (address == `REG_CTRL || address > `REG_FEEDBACK))
        |-> readdata == 32'h00000000)
        else $error("control or unmapped read not zero");
    a_relay_flags: assert property (fault_flags != 3'h0 |-> fault_relay)
        else $error("fault flag set without relay");
    a_inhibit_relay: assert property (pulse_inhibit |-> fault_relay)
        else $error("pulse inhibit without fault");
    a_fault_stops: assert property ($rose(fault_relay) |-> ##[0:1] !fire_enable)
        else $error("firing not stopped on fault");
    a_inhibit_nofire: assert property (pulse_inhibit |-> ##[0:1] !fire_enable)
        else $error("firing while pulses inhibited");
    a_relay_drop: assert property ($fell(fault_relay) |-> fault_flags == 3'h0)
        else $error("fault released with a source still active");
endmodule : scr_supervisor_checker
bind scr_fault_ramp_supervisor scr_supervisor_checker u_chk (.clk(clk), .srst(srst), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .fire_enable(fire_enable),
    .pulse_inhibit(pulse_inhibit), .fault_relay(fault_relay), .fault_flags(fault_flags));
`default_nettype wire

/* File: sim/scr_fault_ramp_supervisor_test.sv */
// self-checking testbench of the thyristor supervisor
`timescale 1ns/1ns
`default_nettype none
`include "scr_supervisor_defines.svh"
module scr_fault_ramp_supervisor_test;
    import scr_supervisor_pkg::*;
    logic clk, srst, read, write, last_on, zero_cross, rot_cw, confirm_req, waitrequest, fire_enable;
    logic pulse_inhibit, fault_relay, system_on, confirm_off, inhibit, ext_block;
    logic [4:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [1:0] strap;
    logic [2:0] sync_lost, fault_flags, fault_req;
    logic [9:0] alpha_in, cur_in, aux_in, phase_delay;
    int err_count, check_count, cycles;
    scr_operator_model u_op (.clk(clk), .fault_req(fault_req), .confirm_req(confirm_req),
        .sync_lost_in(sync_lost), .inhibit_in(inhibit), .external_block_in(ext_block), .confirm_off_in(confirm_off));
    scr_fault_ramp_supervisor dut (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .startup_sel_in(strap),
        .last_state_on_in(last_on), .confirm_off_in(confirm_off), .zero_cross(zero_cross),
        .rotation_cw_in(rot_cw), .sync_lost_in(sync_lost), .inhibit_in(inhibit), .external_block_in(ext_block),
        .alpha_setpoint_in(alpha_in), .voltage_setpoint_in(aux_in), .current_setpoint_in(aux_in),
        .transformer_current_in(aux_in), .shunt_current_in(aux_in), .analog_current_feedback_in(cur_in),
        .direct_voltage_in(aux_in), .analog_voltage_feedback_in(aux_in), .pid_voltage_delay_in(aux_in),
        .pid_current_delay_in(aux_in), .phase_delay(phase_delay), .fire_enable(fire_enable),
        .soft_init_active(), .pulse_inhibit(pulse_inhibit), .fault_relay(fault_relay),
        .fault_flags(fault_flags), .system_on(system_on), .alpha_setpoint(), .voltage_setpoint(),
        .current_setpoint(), .current_feedback(), .voltage_feedback());
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic do_reset(input logic [1:0] sel, input logic last);
        @(posedge clk);
        strap <= sel;
        last_on <= last;
        srst <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(negedge clk);
    endtask : do_reset
    task automatic apply(input logic [2:0] fr, input logic rot, input logic [9:0] cur, input logic [2:0] ef,
        input logic rl = 1'b0);
        @(posedge clk);
        fault_req <= fr;
        rot_cw <= rot;
        cur_in <= cur;
        repeat (6) @(negedge clk);
        cmp({28'h0, fault_relay, fault_flags}, {28'h0, |ef | rl, ef});
    endtask : apply
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_startup;
        logic [1:0] sel [4] = '{`STARTUP_ON, `STARTUP_OFF, `STARTUP_LAST, `STARTUP_LAST};
        for (int i = 0; i < 4; i++) begin
            do_reset(sel[i], i == 2);
            cmp({31'h0, system_on}, {31'h0, i == 0 || i == 2});
        end
        do_reset(`STARTUP_OFF, 1'b0);
    endtask : t_startup
    task automatic t_ramp(input logic [31:0] cmd, input logic dn);
        logic [9:0] prev, d;
        int steps;
        steps = 0;
        bus(1'b1, `REG_CTRL, cmd);
        for (int i = 0; i < 110; i++) begin
            prev = phase_delay;
            @(posedge clk);
            zero_cross <= 1'b1;
            @(posedge clk);
            zero_cross <= 1'b0;
            repeat (2) @(negedge clk);
            d = dn ? prev - phase_delay : phase_delay - prev;
            if (phase_delay != prev) begin
                steps++;
                cmp({31'h0, d > 10'd11}, 32'h0);
            end
        end
        cmp({31'h0, steps >= 90}, 32'h1);
        cmp({22'h0, phase_delay}, {22'h0, dn ? 10'h000 : `DELAY_OFF});
    endtask : t_ramp
    task automatic t_regs;
        bus(1'b0, `REG_MODE, 32'h0);
        cmp(rd, {20'h0, `MODE_RESET});
        bus(1'b0, `REG_LIMIT, 32'h0);
        cmp(rd, {22'h0, `LIMIT_RESET});
        bus(1'b0, 5'h1C, 32'h0);
        cmp(rd, 32'h0);
        bus(1'b1, `REG_RAMP, 32'h00000F83);
        bus(1'b0, `REG_RAMP, 32'h0);
        cmp(rd, 32'h00000F07);
    endtask : t_regs
    task automatic t_faults;
        bus(1'b1, `REG_FAULT_CFG, 32'h00000038);
        bus(1'b1, `REG_LIMIT, 32'h00000100);
        apply(3'h1, 1'b0, 10'h000, 3'h1);
        apply(3'h0, 1'b1, 10'h000, 3'h1);
        apply(3'h2, 1'b0, 10'h000, 3'h2);
        apply(3'h4, 1'b0, 10'h000, 3'h2);
        apply(3'h0, 1'b0, 10'h101, 3'h4);
        apply(3'h0, 1'b0, 10'h100, 3'h0);
        bus(1'b1, `REG_FAULT_CFG, 32'h0000003F);
        apply(3'h7, 1'b1, 10'h3FF, 3'h0);
        apply(3'h0, 1'b0, 10'h000, 3'h0);
    endtask : t_faults
    task automatic t_run(input logic [31:0] cfg, input logic resume);
        bus(1'b1, `REG_FAULT_CFG, cfg);
        bus(1'b1, `REG_CTRL, 32'h1);
        apply(3'h2, 1'b0, 10'h000, 3'h2);
        cmp({30'h0, system_on, pulse_inhibit}, {30'h0, resume, resume});
        apply(3'h0, 1'b0, 10'h000, 3'h0, cfg[6]);
        cmp({31'h0, system_on}, {31'h0, resume});
        @(posedge clk);
        confirm_req <= 1'b1;
        @(posedge clk);
        confirm_req <= 1'b0;
        repeat (4) @(negedge clk);
        cmp({31'h0, fault_relay}, 32'h0);
        bus(1'b1, `REG_CTRL, 32'h2);
    endtask : t_run
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        {srst, read, write, last_on, zero_cross, rot_cw, confirm_req} = 7'h40;
        {address, writedata, strap, fault_req} = '0;
        alpha_in = 10'h3FF;
        cur_in = 10'h000;
        aux_in = 10'h155;
        t_startup();
        bus(1'b1, `REG_FAULT_CFG, 32'h00000038);
        t_ramp(32'h1, 1'b1);
        t_ramp(32'h2, 1'b0);
        t_regs();
        t_faults();
        t_run(32'h000000B8, 1'b1);
        t_run(32'h00000038, 1'b0);
        t_run(32'h00000078, 1'b0);
        finish_test();
    end
endmodule : scr_fault_ramp_supervisor_test
`default_nettype wire
